// file: design/fcs_ctrl.sv
/*
  Flash command launch and status controller: command sequence, one-entry burst
  buffer, protection and access checks, status flags and security update.
  Assumes a same-clock register port, array writes presented on arr_wr, and an
  array that runs each requested operation and reports done and blank.
*/
`timescale 1ns/10ps
// Functional notes
// - status bits 3, 1, 0 read zero; other five status bits always readable
// - writing one to buffer-empty flag clears it and registers the command
// - only burst commands queue; flag sets again as queued burst enters array
// - complete flag set when buffer empty and idle, cleared on launch, not writable
// - program/erase on protected location sets violation flag, drops command; write-one clears
// - broken sequence, program/erase with undivided clock, or stop mid-command sets access error
// - writing one clears access error, writing zero leaves it
// - blank check end sets blank flag only if whole array reads erased
// - blank flag clears on a new valid launch; direct writes ignored
// - codes 05 blank check, 20 byte program, 25 burst program
// - code 40 erases one 512-byte page, 41 erases whole array
// - any other code is illegal and raises access error
// - successful blank check sets security code to unsecured 1:0
// - open bit zero protects whole array against program and erase
module fcs_ctrl
  import fcs_pkg::*;
(
  // clock and reset
  input  wire logic              clk_sys,
  input  wire logic              rst_b,
  // register port
  input  wire logic [ADDR_W-1:0] reg_addr,
  input  wire logic [7:0]        reg_wdata,
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  output logic [7:0]             reg_rdata,
  // array write that opens a command sequence
  input  wire logic              arr_wr,
  input  wire logic [15:0]       arr_addr,
  input  wire logic [7:0]        arr_wdata,
  // array operation port
  output logic                   ar_req,
  output logic [7:0]             ar_op,
  output logic [15:0]            ar_addr,
  output logic [7:0]             ar_data,
  output logic                   ar_tick,
  input  wire logic              ar_done,
  input  wire logic              ar_blank,
  // system
  input  wire logic              stop_req,
  input  wire logic [1:0]        sec_strap,
  output logic [1:0]             security_state_code
);

  import fcs_pkg::*;

  // ==========================================================================
  // state
  logic [6:0]  flash_clock_divider;
  logic        div_set;
  logic [4:0]  flash_protect;
  logic        sec_loaded;
  logic        cmd_buffer_empty_flag;
  logic        cmd_complete_flag;
  logic        protection_violation_flag;
  logic        access_error_flag;
  logic        array_blank_flag;
  fcs_seq_t    seq;
  fcs_seq_t    next_seq;
  logic [7:0]  flash_command;
  logic [15:0] lat_addr;
  logic [7:0]  lat_data;
  logic        buf_full;
  logic [7:0]  buf_code;
  logic [15:0] buf_addr;
  logic [7:0]  buf_data;
  logic [7:0]  run_code;

  fcs_op_if op();

  fcs_engine u_eng (
    .clk_sys  (clk_sys),
    .rst_b    (rst_b),
    .op       (op.engine),
    .ar_req   (ar_req),
    .ar_op    (ar_op),
    .ar_addr  (ar_addr),
    .ar_data  (ar_data),
    .ar_tick  (ar_tick),
    .ar_done  (ar_done),
    .ar_blank (ar_blank)
  );

  // ==========================================================================
  // decode
  wire wr_div  = reg_wr && (reg_addr == OFS_DIV);
  wire wr_prot = reg_wr && (reg_addr == OFS_PROT);
  wire wr_stat = reg_wr && (reg_addr == OFS_STAT);
  wire wr_cmd  = reg_wr && (reg_addr == OFS_CMD);

  // a launch only counts while the buffer is empty; writing one to a clear flag is a no-op
  wire launch_try = wr_stat && reg_wdata[ST_CBE] && cmd_buffer_empty_flag;

  wire is_burst  = (flash_command == CMD_BURST);
  wire is_mass   = (flash_command == CMD_MASS);
  wire cmd_known = (flash_command == CMD_BLANK) || (flash_command == CMD_BYTE) ||
                   is_burst || (flash_command == CMD_PAGE) || is_mass;
  wire is_pe     = cmd_known && (flash_command != CMD_BLANK);

  // protected block sits at the top of the map, 512 bytes << size, capped at 32K
  wire [2:0]  prot_size = (flash_protect[PR_SIZE +: 3] > PROT_MAX) ? PROT_MAX
                                                                 : flash_protect[PR_SIZE +: 3];
  wire [15:0] prot_base = 16'(PROT_BASE << prot_size);
  wire        prot_none = ~flash_protect[PR_OPEN];
  wire        blk_on    = ~flash_protect[PR_DIS];
  wire        addr_prot = prot_none || (blk_on && (lat_addr >= prot_base));
  wire        mass_prot = prot_none || blk_on;
  wire        viol      = is_pe && (is_mass ? mass_prot : addr_prot);

  // only a burst may be queued behind a running operation
  wire acc_launch = (seq != SEQ_CMD) || !cmd_known || (is_pe && !div_set) ||
                    (op.busy && !is_burst);
  // stop entry in the launch cycle drops the new command as well
  wire valid_launch = launch_try && !acc_launch && !viol && !stop_err;
  wire pviol_set    = launch_try && !acc_launch && viol;

  wire arr_err  = arr_wr && (!cmd_buffer_empty_flag || (seq != SEQ_IDLE));
  wire cmd_err  = wr_cmd && (seq != SEQ_DATA);
  wire stop_err = stop_req && (op.busy || buf_full);
  wire acc_set  = (launch_try && acc_launch) || arr_err || cmd_err || stop_err;

  // buffered command enters the array as soon as the engine is free
  wire start = buf_full && !op.busy && !stop_err;

  wire next_cbe = stop_err ? 1'b1 :
                  valid_launch ? 1'b0 :
                  (start && (buf_code == CMD_BURST)) ? 1'b1 :
                  (op.done && (run_code != CMD_BURST)) ? 1'b1 :
                  cmd_buffer_empty_flag;
  wire next_buf = valid_launch || (buf_full && !start && !stop_err);

  // ==========================================================================
  // command sequence
  always_comb begin
    next_seq = seq;
    unique case (seq)
      SEQ_IDLE: begin
        if (arr_wr && !arr_err) begin
          next_seq = SEQ_DATA;
        end
      end
      SEQ_DATA: begin
        if (wr_cmd) begin
          next_seq = SEQ_CMD;
        end
      end
      SEQ_CMD: begin
        if (launch_try) begin
          next_seq = SEQ_IDLE;
        end
      end
      default: begin
        next_seq = SEQ_IDLE;
      end
    endcase
    if (acc_set) begin
      next_seq = SEQ_IDLE;
    end
  end

  wire [7:0] status_rd = {cmd_buffer_empty_flag, cmd_complete_flag, protection_violation_flag,
                          access_error_flag, 1'b0, array_blank_flag, 2'b00};
  wire [7:0] rd_mux = (reg_addr == OFS_DIV)  ? {1'b0, flash_clock_divider} :
                      (reg_addr == OFS_OPT)  ? {6'h00, security_state_code} :
                      (reg_addr == OFS_PROT) ? {3'h0, flash_protect} :
                      (reg_addr == OFS_STAT) ? status_rd :
                      8'h00;

  // ==========================================================================
  // registers
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      seq           <= SEQ_IDLE;
      flash_command <= CMD_RST;
      lat_addr      <= 16'h0000;
      lat_data      <= 8'h00;
    end else begin
      seq <= next_seq;
      if (wr_cmd && (seq == SEQ_DATA)) begin
        flash_command <= reg_wdata;
      end
      if (arr_wr && !arr_err) begin
        lat_addr <= arr_addr;
        lat_data <= arr_wdata;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      buf_full <= 1'b0;
      buf_code <= CMD_RST;
      buf_addr <= 16'h0000;
      buf_data <= 8'h00;
      run_code <= CMD_RST;
    end else begin
      buf_full <= next_buf;
      if (valid_launch) begin
        buf_code <= flash_command;
        buf_addr <= lat_addr;
        buf_data <= lat_data;
      end
      if (start) begin
        run_code <= buf_code;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      cmd_buffer_empty_flag     <= 1'b1;
      cmd_complete_flag         <= 1'b1;
      protection_violation_flag <= 1'b0;
      access_error_flag         <= 1'b0;
      array_blank_flag          <= 1'b0;
    end else begin
      cmd_buffer_empty_flag <= next_cbe;
      cmd_complete_flag     <= next_cbe && !next_buf && !op.busy && !start;
      // hardware set wins over a write-one clear in the same cycle
      protection_violation_flag <= pviol_set ||
                                   (protection_violation_flag && !(wr_stat && reg_wdata[ST_PVIOL]));
      access_error_flag <= acc_set ||
                           (access_error_flag && !(wr_stat && reg_wdata[ST_ACCERR]));
      if (op.done && (run_code == CMD_BLANK)) begin
        array_blank_flag <= op.blank;
      end else if (valid_launch) begin
        array_blank_flag <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      flash_clock_divider <= DIV_RST;
      div_set             <= 1'b0;
      flash_protect       <= PROT_RST;
      sec_loaded          <= 1'b0;
      security_state_code <= SEC_RST;
      reg_rdata           <= 8'h00;
    end else begin
      if (wr_div) begin
        flash_clock_divider <= reg_wdata[6:0];
        div_set             <= 1'b1;
      end
      if (wr_prot) begin
        flash_protect <= reg_wdata[4:0];
      end
      // strap is caught on the first edge after release, not by the reset itself
      sec_loaded <= 1'b1;
      if (!sec_loaded) begin
        security_state_code <= sec_strap;
      end else if (op.done && (run_code == CMD_BLANK) && op.blank) begin
        security_state_code <= SEC_OPEN;
      end
      reg_rdata <= reg_rd ? rd_mux : 8'h00;
    end
  end

  assign op.start   = start;
  assign op.code    = buf_code;
  assign op.addr    = buf_addr;
  assign op.data    = buf_data;
  assign op.abort   = stop_err;
  assign op.clk_div = flash_clock_divider;

  // ==========================================================================
  // assertions
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_b);

  property p_rsvd_zero;
    reg_rd && (reg_addr == OFS_STAT) |=> ((reg_rdata & ST_RSVD) == 8'h00);
  endproperty
  a_rsvd_zero: assert property (p_rsvd_zero) else $error("reserved status bit read one");

  property p_launch_clears;
    valid_launch |=> !cmd_buffer_empty_flag && !cmd_complete_flag && buf_full;
  endproperty
  a_launch_clears: assert property (p_launch_clears) else $error("launch did not clear flags");

  property p_burst_pass;
    start && (buf_code == CMD_BURST) |=> cmd_buffer_empty_flag && op.busy;
  endproperty
  a_burst_pass: assert property (p_burst_pass) else $error("burst pass left buffer full");

  property p_ccf_idle;
    cmd_complete_flag |-> cmd_buffer_empty_flag && !buf_full;
  endproperty
  a_ccf_idle: assert property (p_ccf_idle) else $error("complete while buffer full");

  property p_pviol;
    pviol_set |=> protection_violation_flag && !buf_full && cmd_buffer_empty_flag;
  endproperty
  a_pviol: assert property (p_pviol) else $error("protection violation not flagged");

  property p_acc_keep;
    access_error_flag && wr_stat && !reg_wdata[ST_ACCERR] |=> access_error_flag;
  endproperty
  a_acc_keep: assert property (p_acc_keep) else $error("access error lost on zero write");

  property p_illegal;
    launch_try && !cmd_known |=> access_error_flag && !buf_full;
  endproperty
  a_illegal: assert property (p_illegal) else $error("illegal code not refused");

  property p_blank;
    op.done && (run_code == CMD_BLANK) |=> (array_blank_flag == $past(op.blank));
  endproperty
  a_blank: assert property (p_blank) else $error("blank flag wrong after check");

  property p_sec;
    op.done && (run_code == CMD_BLANK) && op.blank && sec_loaded
      |=> (security_state_code == SEC_OPEN);
  endproperty
  a_sec: assert property (p_sec) else $error("security not opened by blank check");

  property p_closed;
    launch_try && is_pe && !flash_protect[PR_OPEN] |=> !buf_full;
  endproperty
  a_closed: assert property (p_closed) else $error("closed array accepted a command");

  property p_cmd_rd;
    reg_rd && (reg_addr == OFS_CMD) |=> (reg_rdata == 8'h00);
  endproperty
  a_cmd_rd: assert property (p_cmd_rd) else $error("command register read nonzero");

  c_launch: cover property (valid_launch ##[1:40] op.done);
  c_burst2: cover property (start && (buf_code == CMD_BURST) ##[1:40] valid_launch && is_burst);
  c_blank:  cover property (op.done && (run_code == CMD_BLANK) && op.blank);
  c_stop:   cover property (stop_err);

endmodule

// file: design/fcs_engine.sv
/*
  Array engine: program/erase timebase divider and one-at-a-time array request.
  Assumes the array answers on the same clock with a one-cycle done pulse.
*/
`timescale 1ns/10ps
module fcs_engine
  import fcs_pkg::*;
(
  // clock and reset
  input  wire logic        clk_sys,
  input  wire logic        rst_b,
  // controller side
  fcs_op_if.engine         op,
  // array side
  output logic             ar_req,
  output logic [7:0]       ar_op,
  output logic [15:0]      ar_addr,
  output logic [7:0]       ar_data,
  output logic             ar_tick,
  input  wire logic        ar_done,
  input  wire logic        ar_blank
);

  import fcs_pkg::*;

  // ==========================================================================
  // timebase: bus clock / (div+1), or / 8*(div+1) with the prescaler
  logic [8:0] cnt;
  logic [8:0] period_m1;
  logic       wrap;

  assign period_m1 = op.clk_div[DIV_PRE8] ? {op.clk_div[5:0], 3'b111}
                                          : {3'b000, op.clk_div[5:0]};
  assign wrap      = (cnt >= period_m1);

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      cnt     <= 9'h000;
      ar_tick <= 1'b0;
    end else begin
      cnt     <= wrap ? 9'h000 : 9'(cnt + 9'h001);
      ar_tick <= wrap;
    end
  end

  // ==========================================================================
  // request: held until the array reports done or the controller aborts
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      op.busy  <= 1'b0;
      op.done  <= 1'b0;
      op.blank <= 1'b0;
      ar_req   <= 1'b0;
      ar_op    <= 8'h00;
      ar_addr  <= 16'h0000;
      ar_data  <= 8'h00;
    end else begin
      op.done <= 1'b0;
      if (!op.busy && op.start) begin
        op.busy <= 1'b1;
        ar_req  <= 1'b1;
        ar_op   <= op.code;
        ar_addr <= op.addr;
        ar_data <= op.data;
      end else if (op.busy && op.abort) begin
        op.busy <= 1'b0;
        ar_req  <= 1'b0;
      end else if (op.busy && ar_done) begin
        op.busy  <= 1'b0;
        op.done  <= 1'b1;
        op.blank <= ar_blank;
        ar_req   <= 1'b0;
      end
    end
  end

endmodule

// file: design/fcs_op_if.sv
/*
  Operation hand-off between the command controller and the array engine.
  Assumes both ends run on the same clock.
*/
`timescale 1ns/10ps
interface fcs_op_if;
  logic       start;
  logic [7:0] code;
  logic [15:0] addr;
  logic [7:0] data;
  logic       abort;
  logic [6:0] clk_div;
  logic       busy;
  logic       done;
  logic       blank;

  modport ctrl   (output start, code, addr, data, abort, clk_div,
                  input  busy, done, blank);
  modport engine (input  start, code, addr, data, abort, clk_div,
                  output busy, done, blank);
endinterface

// file: design/fcs_pkg.sv
/*
  Constants, register map and types for the flash command and status controller.
  Assumes a byte-wide register port with a 3-bit word index and a 16-bit array address.
*/
package fcs_pkg;

  // ==========================================================================
  // register port
  localparam int unsigned ADDR_W    = 3;
  localparam logic [2:0]  OFS_DIV   = 3'h0;  // clock divider, read/write
  localparam logic [2:0]  OFS_OPT   = 3'h1;  // options, security code, read only
  localparam logic [2:0]  OFS_PROT  = 3'h3;  // protection, read/write
  localparam logic [2:0]  OFS_STAT  = 3'h5;  // flash_status
  localparam logic [2:0]  OFS_CMD   = 3'h6;  // flash_command, write only

  // ==========================================================================
  // flash_status fields
  localparam int unsigned ST_CBE    = 7;
  localparam int unsigned ST_CCF    = 6;
  localparam int unsigned ST_PVIOL  = 5;
  localparam int unsigned ST_ACCERR = 4;
  localparam int unsigned ST_BLANK  = 2;
  localparam logic [7:0]  ST_RSVD   = 8'h0B;

  // ==========================================================================
  // divider and protection fields
  localparam int unsigned DIV_PRE8  = 6;
  localparam int unsigned PR_OPEN   = 4;
  localparam int unsigned PR_DIS    = 3;
  localparam int unsigned PR_SIZE   = 0;
  localparam logic [6:0]  DIV_RST   = 7'h00;
  localparam logic [4:0]  PROT_RST  = 5'h18;
  localparam logic [7:0]  CMD_RST   = 8'h00;

  // ==========================================================================
  // command codes
  localparam logic [7:0]  CMD_BLANK = 8'h05;
  localparam logic [7:0]  CMD_BYTE  = 8'h20;
  localparam logic [7:0]  CMD_BURST = 8'h25;
  localparam logic [7:0]  CMD_PAGE  = 8'h40;
  localparam logic [7:0]  CMD_MASS  = 8'h41;

  // ==========================================================================
  // protection and security
  localparam logic [15:0] PROT_BASE = 16'hFE00;
  localparam logic [2:0]  PROT_MAX  = 3'h6;
  localparam logic [1:0]  SEC_OPEN  = 2'h2;
  localparam logic [1:0]  SEC_RST   = 2'h0;

  // command sequence, gray from SEQ_IDLE through SEQ_DATA to SEQ_CMD
  typedef enum logic [1:0] {
    SEQ_IDLE = 2'b00,
    SEQ_DATA = 2'b01,
    SEQ_CMD  = 2'b11
  } fcs_seq_t;

endpackage

// file: tb/flash_command_status_ctrl_test.sv
/*
  Self-checking bench for the flash command and status controller.
  Assumes fcs_ctrl and fcs_pkg; the bench plays software, the array and the
  system around the block, on one 200 MHz clock.
*/
`timescale 1ns/10ps
module flash_command_status_ctrl_test;
  import fcs_pkg::*;

  // ==========================================================================
  // design inputs and outputs
  logic              clk_sys   = 1'b0;
  logic              rst_b     = 1'b0;
  logic [ADDR_W-1:0] reg_addr  = '0;
  logic [7:0]        reg_wdata = 8'h00;
  logic              reg_wr    = 1'b0;
  logic              reg_rd    = 1'b0;
  logic [7:0]        reg_rdata;
  logic              arr_wr    = 1'b0;
  logic [15:0]       arr_addr  = 16'h0000;
  logic [7:0]        arr_wdata = 8'h00;
  logic              ar_req;
  logic [7:0]        ar_op;
  logic [15:0]       ar_addr;
  logic [7:0]        ar_data;
  logic              ar_tick;
  logic              ar_done   = 1'b0;
  logic              ar_blank  = 1'b0;
  logic              stop_req  = 1'b0;
  logic [1:0]        sec_strap = 2'h1;
  logic [1:0]        security_state_code;
  int                err_total = 0;
  int                n_tests   = 0;

  always #2.5 clk_sys = ~clk_sys;

  fcs_ctrl DUT (
    .clk_sys(clk_sys), .rst_b(rst_b),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata),
    .arr_wr(arr_wr), .arr_addr(arr_addr), .arr_wdata(arr_wdata),
    .ar_req(ar_req), .ar_op(ar_op), .ar_addr(ar_addr), .ar_data(ar_data), .ar_tick(ar_tick),
    .ar_done(ar_done), .ar_blank(ar_blank),
    .stop_req(stop_req), .sec_strap(sec_strap),
    .security_state_code(security_state_code)
  );

  // ==========================================================================
  // shared tasks
  task automatic finish_test;
    $display("comparisons %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask

  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask

  // read data stand only in the cycle after the strobe
  task automatic rchk(input string what, input logic [2:0] a, input logic [7:0] e);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1;
    chk(what, {8'h00, reg_rdata}, {8'h00, e});
  endtask

  // array write, command code, then launch through the buffer-empty flag
  task automatic launch(input logic [7:0] code, input logic [15:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    arr_wr    <= 1'b1;
    arr_addr  <= a;
    arr_wdata <= d;
    @(posedge clk_sys);
    arr_wr <= 1'b0;
    wr(OFS_CMD, code);
    wr(OFS_STAT, 8'h80);
  endtask

  // bounded wait for the array request, then compare what it carries
  task automatic wait_req(input logic [7:0] code, input logic [15:0] a);
    int i;
    i = 0;
    while (ar_req !== 1'b1 && i < 50) begin
      cyc(1);
      i++;
    end
    chk("ar_req", {15'h0000, ar_req}, 16'h0001);
    chk("ar_op", {8'h00, ar_op}, {8'h00, code});
    chk("ar_addr", ar_addr, a);
  endtask

  task automatic finish_op(input logic b);
    @(posedge clk_sys);
    ar_done  <= 1'b1;
    ar_blank <= b;
    @(posedge clk_sys);
    ar_done  <= 1'b0;
    ar_blank <= 1'b0;
    cyc(3);
  endtask

  // ==========================================================================
  // scenarios
  task automatic t_reset_regs;
    rchk("status reset", OFS_STAT, 8'hC0);
    rchk("command read", OFS_CMD, 8'h00);
    rchk("security strap", OFS_OPT, 8'h01);
    rchk("divider reset", OFS_DIV, 8'h00);
    rchk("protection reset", OFS_PROT, 8'h18);
    rchk("unmapped index", 3'h7, 8'h00);
    wr(OFS_STAT, 8'h4F);
    rchk("status reserved", OFS_STAT, 8'hC0);
    wr(OFS_CMD, CMD_BYTE);
    rchk("command outside sequence", OFS_STAT, 8'hD0);
    rchk("command still reads zero", OFS_CMD, 8'h00);
    wr(OFS_STAT, 8'h00);
    rchk("access error kept", OFS_STAT, 8'hD0);
    wr(OFS_STAT, 8'h10);
    rchk("access error cleared", OFS_STAT, 8'hC0);
  endtask

  task automatic t_no_divider;
    launch(CMD_BYTE, 16'h1000, 8'h5A);
    rchk("program before divider", OFS_STAT, 8'hD0);
    chk("no request", {15'h0000, ar_req}, 16'h0000);
    wr(OFS_STAT, 8'h10);
    wr(OFS_DIV, 8'h13);
  endtask

  task automatic t_codes;
    logic [7:0] codes [4];
    codes = '{CMD_BYTE, CMD_PAGE, CMD_MASS, CMD_BLANK};
    foreach (codes[k]) begin
      launch(codes[k], 16'h1200, 8'hA5);
      rchk("status launched", OFS_STAT, 8'h00);
      wait_req(codes[k], 16'h1200);
      if (codes[k] == CMD_BYTE) begin
        chk("ar_data", {8'h00, ar_data}, 16'h00A5);
      end
      finish_op(1'b0);
      rchk("status complete", OFS_STAT, 8'hC0);
    end
    chk("still secure", {14'h0000, security_state_code}, 16'h0001);
  endtask

  task automatic t_blank;
    launch(CMD_BLANK, 16'h0000, 8'hFF);
    wait_req(CMD_BLANK, 16'h0000);
    finish_op(1'b1);
    rchk("blank set", OFS_STAT, 8'hC4);
    chk("unsecured", {14'h0000, security_state_code}, {14'h0000, SEC_OPEN});
    rchk("unsecured read", OFS_OPT, {6'h00, SEC_OPEN});
    wr(OFS_STAT, 8'h00);
    rchk("blank not writable", OFS_STAT, 8'hC4);
    launch(8'h33, 16'h1000, 8'h00);
    rchk("illegal keeps blank", OFS_STAT, 8'hD4);
    wr(OFS_STAT, 8'h10);
    launch(CMD_BYTE, 16'h1001, 8'h00);
    rchk("valid launch clears blank", OFS_STAT, 8'h00);
    wait_req(CMD_BYTE, 16'h1001);
    finish_op(1'b0);
  endtask

  task automatic t_illegal;
    logic [7:0] bad [4];
    bad = '{8'h00, 8'h24, 8'h42, 8'hFF};
    foreach (bad[k]) begin
      launch(bad[k], 16'h1000, 8'h00);
      rchk("illegal code", OFS_STAT, 8'hD0);
      chk("illegal no request", {15'h0000, ar_req}, 16'h0000);
      wr(OFS_STAT, 8'h10);
    end
  endtask

  task automatic t_protect;
    wr(OFS_PROT, 8'h08);
    launch(CMD_BYTE, 16'h1000, 8'h11);
    rchk("closed array", OFS_STAT, 8'hE0);
    chk("closed no request", {15'h0000, ar_req}, 16'h0000);
    wr(OFS_STAT, 8'h20);
    rchk("violation cleared", OFS_STAT, 8'hC0);
    wr(OFS_PROT, 8'h10);
    launch(CMD_PAGE, 16'hFE00, 8'h00);
    rchk("protected page", OFS_STAT, 8'hE0);
    wr(OFS_STAT, 8'h20);
    launch(CMD_BYTE, 16'hFDFF, 8'h22);
    wait_req(CMD_BYTE, 16'hFDFF);
    finish_op(1'b0);
    wr(OFS_PROT, 8'h18);
  endtask

  task automatic t_burst;
    launch(CMD_BURST, 16'h3000, 8'h01);
    wait_req(CMD_BURST, 16'h3000);
    rchk("burst accepted", OFS_STAT, 8'h80);
    launch(CMD_BURST, 16'h3001, 8'h02);
    rchk("burst queued", OFS_STAT, 8'h00);
    finish_op(1'b0);
    rchk("queued entered", OFS_STAT, 8'h80);
    chk("second address", ar_addr, 16'h3001);
    finish_op(1'b0);
    rchk("burst complete", OFS_STAT, 8'hC0);
  endtask

  task automatic t_stop;
    launch(CMD_PAGE, 16'h2000, 8'h00);
    wait_req(CMD_PAGE, 16'h2000);
    @(posedge clk_sys);
    stop_req <= 1'b1;
    @(posedge clk_sys);
    stop_req <= 1'b0;
    cyc(2);
    chk("stop aborts", {15'h0000, ar_req}, 16'h0000);
    rchk("stop error", OFS_STAT, 8'hD0);
    wr(OFS_STAT, 8'h10);
    rchk("stop cleared", OFS_STAT, 8'hC0);
  endtask

  // a second array write inside an open sequence breaks it
  task automatic t_seq_err;
    repeat (2) begin
      @(posedge clk_sys);
      arr_wr <= 1'b1;
      @(posedge clk_sys);
      arr_wr <= 1'b0;
    end
    rchk("array write in sequence", OFS_STAT, 8'hD0);
    wr(OFS_STAT, 8'h10);
  endtask

  // timebase period in bus clocks, plain and with the divide-by-eight prescaler
  task automatic t_tick;
    int          gap;
    logic [7:0]  divs [2];
    logic [15:0] per [2];
    divs = '{8'h13, 8'h41};
    per  = '{16'h0014, 16'h0010};
    foreach (divs[k]) begin
      wr(OFS_DIV, divs[k]);
      cyc(1);
      gap = 0;
      while (ar_tick !== 1'b1 && gap < 200) begin
        cyc(1);
        gap++;
      end
      cyc(1);
      gap = 1;
      while (ar_tick !== 1'b1 && gap < 200) begin
        cyc(1);
        gap++;
      end
      chk("tick period", 16'(gap), per[k]);
    end
  endtask

  // ==========================================================================
  // main sequence and watchdog
  initial begin
    repeat (8) @(posedge clk_sys);
    rst_b <= 1'b1;
    cyc(2);
    t_reset_regs();
    t_no_divider();
    t_codes();
    t_blank();
    t_illegal();
    t_seq_err();
    t_protect();
    t_burst();
    t_stop();
    t_tick();
    finish_test();
  end

  // the whole run needs well under two thousand cycles
  initial begin
    repeat (20000) @(posedge clk_sys);
    err_total++;
    finish_test();
  end
endmodule
